/* mtpci_periph.sv */
/*
  Timer with prescaler, bit-programmable ports with pull-up control,
  falling-edge port interrupt, carrier synthesizer and interrupt flags.
  Assumes one clock mclk (the oscillator), Avalon-MM register access,
  and a CPU core that pulses cpuIntAck when it takes the vector.
*/
`timescale 1ns/10ps
module mtpci_periph
  import mtpci_pkg::*;
#(
  parameter bit OPT_PINT       = 1'b0,
  parameter int CARRIER_PREDIV = 8
) (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        extCountPin,
  input  wire logic [3:0]  portAIn,
  input  wire logic [3:0]  portBIn,
  input  wire logic [3:0]  portCIn,
  input  wire logic [1:0]  portDIn,
  output logic      [3:0]  portAOut,
  output logic      [3:0]  portBOut,
  output logic      [3:0]  portCOut,
  output logic      [1:0]  portDOut,
  output logic      [3:0]  portAOe,
  output logic      [3:0]  portBOe,
  output logic      [3:0]  portCOe,
  output logic      [1:0]  portDOe,
  output logic      [3:0]  portAPullup,
  output logic      [3:0]  portBPullup,
  output logic      [3:0]  portCPullup,
  output logic      [1:0]  portDPullup,
  output logic             carrierOutPin,
  input  wire logic        cpuIntAck,
  output logic             irqPending,
  output logic      [11:0] irqVector,
  output logic             wakeRequest
);

  if (CARRIER_PREDIV < 1 || CARRIER_PREDIV > 256) begin : g_bad_prediv
    $error("CARRIER_PREDIV must lie in 1..256");
  end

  logic        waitReq_reg;
  logic [31:0] rdData_reg;
  logic [3:0]  irqEn_reg;
  logic [3:0]  irqReq_reg;
  logic [2:0]  tmrMode_reg;
  logic [3:0]  loadLo_reg;
  logic [7:0]  loadVal_reg;
  logic [7:0]  tmrCnt_reg;
  logic [3:0]  rdLowLatch_reg;
  logic [13:0] portData_reg;
  logic [13:0] portDir_reg;
  logic [13:0] pullup_reg;
  logic        remData_reg;
  logic [3:0]  pfc_reg;
  logic [1:0]  extCtrl_reg;
  logic [1:0]  instrCyc_reg;
  logic [PRE_W-1:0] preCnt_reg;
  logic        extPrev_reg;
  logic        pintArmed_reg;
  logic [7:0]  preDiv_reg;
  logic [3:0]  carCnt_reg;
  logic        carOut_reg;
  logic        pending_reg;
  logic [11:0] vector_reg;

  logic        accept;
  logic        doWr;
  logic        doRd;
  logic [3:0]  wNib;
  logic        oscTick;
  logic        srcPulse;
  logic        extHit;
  logic [PRE_W-1:0] preMask;
  logic        preTick;
  logic        loadWr;
  logic        tmrWrap;
  logic [13:0] pinIn;
  logic [13:0] pinView;
  logic [13:0] pintSrc;
  logic        allHigh;
  logic        portEvent;
  mtpci_carrier_e carMode;
  logic        fxTick;
  logic [3:0]  carPeriod;
  logic [3:0]  carHighCnt;
  logic [3:0]  enEff;
  logic [3:0]  irqMask;

  // only the timer and port flags exist; the other bits stay zero
  assign irqMask = (4'h1 << IRQ_TMR_BIT) | (4'h1 << IRQ_PORT_BIT);

  // bus slave: one wait cycle, then answer
  assign accept = (avs_read || avs_write) && waitReq_reg;
  assign doWr   = accept && avs_write && avs_byteenable[0];
  assign doRd   = accept && avs_read && !avs_write;
  assign wNib   = avs_writedata[3:0];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) waitReq_reg <= 1'b1;
    else        waitReq_reg <= !accept;
  end

  assign pinIn   = {portDIn, portCIn, portBIn, portAIn};
  // inputs show the pin, outputs show the latch
  assign pinView = (pinIn & ~portDir_reg) | (portData_reg & portDir_reg);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdData_reg     <= 32'h0000_0000;
      rdLowLatch_reg <= 4'h0;
    end else if (doRd) begin
      rdData_reg <= 32'h0000_0000;
      if (avs_address == IDX_IRQ_EN)        rdData_reg[3:0] <= irqEn_reg;
      else if (avs_address == IDX_IRQ_REQ)  rdData_reg[3:0] <= irqReq_reg;
      else if (avs_address == IDX_TMR_MODE) rdData_reg[2:0] <= tmrMode_reg;
      else if (avs_address == IDX_TMR_HI) begin
        rdData_reg[3:0] <= tmrCnt_reg[7:4];
        rdLowLatch_reg  <= tmrCnt_reg[3:0];
      end
      else if (avs_address == IDX_TMR_LO)   rdData_reg[3:0] <= rdLowLatch_reg;
      else if (avs_address == IDX_PORT_A)   rdData_reg[3:0] <= pinView[3:0];
      else if (avs_address == IDX_PORT_B)   rdData_reg[3:0] <= pinView[7:4];
      else if (avs_address == IDX_PORT_C)   rdData_reg[3:0] <= pinView[11:8];
      else if (avs_address == IDX_PORT_D)   rdData_reg[1:0] <= pinView[13:12];
      else if (avs_address == IDX_REM)      rdData_reg[0]   <= remData_reg;
    end
  end

  assign avs_waitrequest = waitReq_reg;
  assign avs_readdata    = rdData_reg;

  // write-only and plain control registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tmrMode_reg  <= TMR_MODE_RST;
      portData_reg <= PORT_RST;
      portDir_reg  <= PORT_RST;
      remData_reg  <= 1'b0;
      pfc_reg      <= PFC_RST;
      extCtrl_reg  <= EXT_CTRL_RST;
    end else if (doWr) begin
      if (avs_address == IDX_TMR_MODE)    tmrMode_reg          <= wNib[2:0];
      else if (avs_address == IDX_PORT_A) portData_reg[3:0]    <= wNib;
      else if (avs_address == IDX_PORT_B) portData_reg[7:4]    <= wNib;
      else if (avs_address == IDX_PORT_C) portData_reg[11:8]   <= wNib;
      else if (avs_address == IDX_PORT_D) portData_reg[13:12]  <= wNib[1:0];
      else if (avs_address == IDX_REM)    remData_reg          <= wNib[0];
      else if (avs_address == IDX_PFC)    pfc_reg              <= wNib;
      else if (avs_address == IDX_DIR_A)  portDir_reg[3:0]     <= wNib;
      else if (avs_address == IDX_DIR_B)  portDir_reg[7:4]     <= wNib;
      else if (avs_address == IDX_DIR_C)  portDir_reg[11:8]    <= wNib;
      else if (avs_address == IDX_DIR_D)  portDir_reg[13:12]   <= wNib[1:0];
      else if (avs_address == IDX_EXT_CTRL) extCtrl_reg        <= wNib[1:0];
    end
  end

  // pins
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) pullup_reg <= PORT_RST;
    else        pullup_reg <= {14{pfc_reg[PFC_PULL_BIT]}} & portData_reg;
  end

  assign portAOut    = portData_reg[3:0];
  assign portBOut    = portData_reg[7:4];
  assign portCOut    = portData_reg[11:8];
  assign portDOut    = portData_reg[13:12];
  assign portAOe     = portDir_reg[3:0];
  assign portBOe     = portDir_reg[7:4];
  assign portCOe     = portDir_reg[11:8];
  assign portDOe     = portDir_reg[13:12];
  assign portAPullup = pullup_reg[3:0];
  assign portBPullup = pullup_reg[7:4];
  assign portCPullup = pullup_reg[11:8];
  assign portDPullup = pullup_reg[13:12];

  // instruction cycle and count source
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      instrCyc_reg <= 2'h0;
      extPrev_reg  <= 1'b0;
    end else begin
      instrCyc_reg <= instrCyc_reg + 2'h1;
      extPrev_reg  <= extCountPin;
    end
  end

  assign oscTick  = (instrCyc_reg == INSTR_CYC_LAST);
  assign extHit   = extCtrl_reg[EXT_EDGE_BIT] ? (extPrev_reg && !extCountPin)
                                              : (!extPrev_reg && extCountPin);
  assign srcPulse = extCtrl_reg[EXT_SRC_BIT] ? extHit : oscTick;

  // prescaler: overflow when the selected low bits are all ones
  assign preMask = (11'h7FF >> (4'hB - PRE_SHIFT[tmrMode_reg]));
  assign preTick = srcPulse && ((preCnt_reg | ~preMask) == 11'h7FF);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n)        preCnt_reg <= 11'h000;
    else if (srcPulse) preCnt_reg <= preCnt_reg + 11'h001;
  end

  // timer counter and load value
  assign loadWr  = doWr && (avs_address == IDX_TMR_HI);
  assign tmrWrap = preTick && (tmrCnt_reg == TMR_MAX) && !loadWr;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      loadLo_reg  <= 4'h0;
      loadVal_reg <= TMR_RST;
      tmrCnt_reg  <= TMR_RST;
    end else begin
      if (doWr && avs_address == IDX_TMR_LO) loadLo_reg <= wNib;
      if (loadWr) begin
        loadVal_reg <= {wNib, loadLo_reg};
        tmrCnt_reg  <= {wNib, loadLo_reg};
      end else if (tmrWrap) begin
        tmrCnt_reg <= loadVal_reg;
      end else if (preTick) begin
        tmrCnt_reg <= tmrCnt_reg + 8'h01;
      end
    end
  end

  // port interrupt: one combined edge detector over input sources
  assign pintSrc   = (OPT_PINT ? PINT_SRC_OPT : PINT_SRC_DFLT) & ~portDir_reg;
  assign allHigh   = &(pinIn | ~pintSrc);
  assign portEvent = pintArmed_reg && !allHigh;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n)         pintArmed_reg <= 1'b0;
    else if (allHigh)   pintArmed_reg <= 1'b1;
    else if (portEvent) pintArmed_reg <= 1'b0;
  end

  // interrupt flags; hardware set wins over a software clear
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irqReq_reg <= IRQ_REQ_RST;
    end else begin
      irqReq_reg <= ((doWr && avs_address == IDX_IRQ_REQ) ? (wNib & irqMask) : irqReq_reg)
                  | ({3'h0, portEvent} << IRQ_PORT_BIT)
                  | ({3'h0, tmrWrap} << IRQ_TMR_BIT);
    end
  end

  // the core's acknowledge beats a same-cycle enable write
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n)                                irqEn_reg <= IRQ_EN_RST;
    else if (cpuIntAck)                        irqEn_reg <= 4'h0;
    else if (doWr && avs_address == IDX_IRQ_EN) irqEn_reg <= wNib & irqMask;
  end

  assign enEff = irqEn_reg & irqReq_reg;

  // vector held for the core, which pushes PC and carry itself
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pending_reg <= 1'b0;
      vector_reg  <= VEC_RESET;
    end else begin
      pending_reg <= (enEff != 4'h0) && !cpuIntAck;
      if (enEff[IRQ_TMR_BIT])       vector_reg <= VEC_TIMER;
      else if (enEff[IRQ_PORT_BIT]) vector_reg <= VEC_PORT;
    end
  end

  assign irqPending  = pending_reg;
  assign irqVector   = vector_reg;
  // the timer never stops, so a halted core sees this
  assign wakeRequest = pending_reg;

  // carrier synthesizer
  assign carMode = mtpci_carrier_e'({pfc_reg[1], pfc_reg[0]});
  assign fxTick  = !pfc_reg[PFC_CPS_BIT] || (preDiv_reg == 8'(CARRIER_PREDIV - 1));

  always_comb begin
    carPeriod  = CAR_PERIOD_12;
    carHighCnt = CAR_HIGH_HALF12;
    case (carMode)
      CAR_D8_HALF: begin
        carPeriod  = CAR_PERIOD_8;
        carHighCnt = CAR_HIGH_HALF8;
      end
      CAR_D12_THIRD: begin
        carHighCnt = CAR_HIGH_THIRD;
      end
      default: begin
        carPeriod  = CAR_PERIOD_12;
        carHighCnt = CAR_HIGH_HALF12;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      preDiv_reg <= 8'h00;
      carCnt_reg <= 4'h0;
    end else begin
      preDiv_reg <= fxTick ? 8'h00 : preDiv_reg + 8'h01;
      if (carMode == CAR_NONE) carCnt_reg <= 4'h0;
      else if (fxTick)         carCnt_reg <= (carCnt_reg >= carPeriod - 4'h1) ? 4'h0 : carCnt_reg + 4'h1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n)                   carOut_reg <= 1'b0;
    else if (carMode == CAR_NONE) carOut_reg <= remData_reg;
    else                          carOut_reg <= remData_reg && (carCnt_reg < carHighCnt);
  end

  assign carrierOutPin = carOut_reg;

  AST_TMR_WRAP_IRQ: assert property (@(posedge mclk) disable iff (!rst_n)
    tmrWrap |=> irqReq_reg[IRQ_TMR_BIT]) else $error("wrap did not set timer request");
  AST_TMR_STEP: assert property (@(posedge mclk) disable iff (!rst_n)
    preTick && !loadWr && tmrCnt_reg != TMR_MAX |=> tmrCnt_reg == $past(tmrCnt_reg) + 8'h01)
    else $error("counter did not step on prescaler overflow");
  AST_TMR_HOLD: assert property (@(posedge mclk) disable iff (!rst_n)
    !preTick && !loadWr |=> $stable(tmrCnt_reg)) else $error("counter moved without overflow");
  AST_TMR_RELOAD: assert property (@(posedge mclk) disable iff (!rst_n)
    tmrWrap |=> tmrCnt_reg == $past(loadVal_reg)) else $error("overflow did not reload");
  AST_PRESC_UNITY: assert property (@(posedge mclk) disable iff (!rst_n)
    srcPulse && tmrMode_reg == 3'h7 |-> preTick) else $error("divide by one missed a pulse");
  AST_INSTR_CYCLE: assert property (@(posedge mclk) disable iff (!rst_n)
    oscTick |=> (!oscTick) [*3] ##1 oscTick) else $error("instruction cycle not four clocks");
  AST_PINT_ONCE: assert property (@(posedge mclk) disable iff (!rst_n)
    (portEvent || !pintArmed_reg) && !allHigh |=> !portEvent) else $error("second edge while blocked");
  AST_ACK_CLEARS_EN: assert property (@(posedge mclk) disable iff (!rst_n)
    cpuIntAck |=> irqEn_reg == 4'h0 && !irqPending) else $error("enables not cleared on entry");
  AST_PENDING: assert property (@(posedge mclk) disable iff (!rst_n)
    enEff != 4'h0 && !cpuIntAck |=> irqPending ##0 wakeRequest) else $error("enabled request not pending");
  AST_TMR_VECTOR: assert property (@(posedge mclk) disable iff (!rst_n)
    enEff[IRQ_TMR_BIT] |=> irqVector == VEC_TIMER) else $error("timer vector wrong");
  AST_REQ_STICKY: assert property (@(posedge mclk) disable iff (!rst_n)
    irqReq_reg[IRQ_TMR_BIT] && !(doWr && avs_address == IDX_IRQ_REQ) |=> irqReq_reg[IRQ_TMR_BIT])
    else $error("timer request dropped without a write");
  AST_REM_PLAIN: assert property (@(posedge mclk) disable iff (!rst_n)
    carMode == CAR_NONE |=> carrierOutPin == $past(remData_reg)) else $error("plain data not on pin");

endmodule : mtpci_periph

/* mtpci_pkg.sv */
/*
  Shared constants for the timer, port, carrier and interrupt block:
  register word indices, field positions, reset values, vectors.
  Assumes a 32-bit Avalon-MM slave with one register per aligned word.
*/
package mtpci_pkg;
  localparam int          ADDR_W          = 5;
  // word index; byte address is four times the index
  localparam logic [4:0]  IDX_IRQ_EN      = 5'h00;
  localparam logic [4:0]  IDX_IRQ_REQ     = 5'h01;
  localparam logic [4:0]  IDX_TMR_MODE    = 5'h02;
  localparam logic [4:0]  IDX_TMR_LO      = 5'h04;
  localparam logic [4:0]  IDX_TMR_HI      = 5'h05;
  localparam logic [4:0]  IDX_PORT_A      = 5'h08;
  localparam logic [4:0]  IDX_PORT_B      = 5'h09;
  localparam logic [4:0]  IDX_PORT_C      = 5'h0A;
  localparam logic [4:0]  IDX_PORT_D      = 5'h0B;
  localparam logic [4:0]  IDX_REM         = 5'h0D;
  localparam logic [4:0]  IDX_PFC         = 5'h13;
  localparam logic [4:0]  IDX_DIR_A       = 5'h16;
  localparam logic [4:0]  IDX_DIR_B       = 5'h17;
  localparam logic [4:0]  IDX_DIR_C       = 5'h18;
  localparam logic [4:0]  IDX_DIR_D       = 5'h19;
  localparam logic [4:0]  IDX_EXT_CTRL    = 5'h1C;
  localparam int          IRQ_TMR_BIT     = 2;
  localparam int          IRQ_PORT_BIT    = 0;
  localparam int          PFC_PULL_BIT    = 3;
  localparam int          PFC_CPS_BIT     = 2;
  localparam int          EXT_EDGE_BIT    = 0;
  localparam int          EXT_SRC_BIT     = 1;
  localparam logic [3:0]  IRQ_EN_RST      = 4'h0;
  localparam logic [3:0]  IRQ_REQ_RST     = 4'h0;
  localparam logic [2:0]  TMR_MODE_RST    = 3'h0;
  localparam logic [7:0]  TMR_RST         = 8'h00;
  localparam logic [7:0]  TMR_MAX         = 8'hFF;
  localparam logic [13:0] PORT_RST        = 14'h0000;
  localparam logic [3:0]  PFC_RST         = 4'h0;
  localparam logic [1:0]  EXT_CTRL_RST    = 2'h0;
  localparam logic [1:0]  INSTR_CYC_LAST  = 2'h3;
  localparam int          PRE_W           = 11;
  // prescaler exponent per select code, 2048 down to 1
  localparam logic [3:0]  PRE_SHIFT [8]   = '{4'hB, 4'h9, 4'h7, 4'h5, 4'h3, 4'h2, 4'h1, 4'h0};
  localparam logic [3:0]  CAR_PERIOD_8    = 4'h8;
  localparam logic [3:0]  CAR_PERIOD_12   = 4'hC;
  localparam logic [3:0]  CAR_HIGH_HALF8  = 4'h4;
  localparam logic [3:0]  CAR_HIGH_THIRD  = 4'h4;
  localparam logic [3:0]  CAR_HIGH_HALF12 = 4'h6;
  localparam logic [11:0] VEC_RESET       = 12'h000;
  localparam logic [11:0] VEC_TIMER       = 12'h002;
  localparam logic [11:0] VEC_PORT        = 12'h004;
  // port interrupt sources: default B and C, option A1-3, B0-3, C0
  localparam logic [13:0] PINT_SRC_DFLT   = 14'h0FF0;
  localparam logic [13:0] PINT_SRC_OPT    = 14'h01FE;
  typedef enum logic [1:0] {CAR_NONE, CAR_D8_HALF, CAR_D12_THIRD, CAR_D12_HALF} mtpci_carrier_e;
endpackage : mtpci_pkg

/* mtpci_pins.sv */
/*
  Far-side model: resolves the fourteen port pins and plays the core's
  interrupt acknowledge. Assumes the bench supplies its own pin drive.
*/
`timescale 1ns/10ps
module mtpci_pins (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic [13:0] pinOut,
  input  wire logic [13:0] pinOe,
  input  wire logic [13:0] pinPull,
  input  wire logic [13:0] drvVal,
  input  wire logic [13:0] drvEn,
  input  wire logic        irqPending,
  input  wire logic        ackEn,
  output logic      [13:0] pinLevel,
  output logic             cpuIntAck
);
  logic [13:0] float_reg;
  // undriven pins wander so a stale level never passes for a real one
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) float_reg <= 14'h0000;
    else float_reg <= ~float_reg;
  end
  always_comb begin
    for (int i = 0; i < 14; i++) begin
      if (pinOe[i]) pinLevel[i] = pinOut[i];
      else if (drvEn[i]) pinLevel[i] = drvVal[i];
      else if (pinPull[i]) pinLevel[i] = 1'b1;
      else pinLevel[i] = float_reg[i];
    end
  end
  // one acknowledge per taken interrupt, as the core would
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) cpuIntAck <= 1'b0;
    else cpuIntAck <= irqPending & ackEn & ~cpuIntAck;
  end
endmodule : mtpci_pins

/* mtpci_periph_tb.sv */
/*
  Self-checking bench for mtpci_periph: registers, pins, port and timer
  interrupts, carrier and prescaler. Assumes mtpci_pins as far side.
*/
`timescale 1ns/10ps
module mtpci_periph_tb;
  import mtpci_pkg::*;
  localparam int PREDIV = 2;
  logic        mclk;
  logic        rst_n;
  logic [4:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        extCountPin;
  logic        carrierOutPin;
  logic        irqPending;
  logic        wakeRequest;
  logic        cpuIntAck;
  logic        ackEn;
  logic        prev;
  logic [11:0] irqVector;
  logic [13:0] drvVal;
  logic [13:0] drvEn;
  wire  [13:0] pinOut;
  wire  [13:0] pinOe;
  wire  [13:0] pinPull;
  wire  [13:0] pinLevel;
  logic [3:0]  rd;
  logic [7:0]  t1;
  logic [7:0]  t2;
  logic [15:0] rv;
  logic [15:0] dv;
  int          errors;
  int          n_compared;
  int          highs;
  int          rises;
  int          ratio [8] = '{2048, 512, 128, 32, 8, 4, 2, 1};
  logic [4:0]  rstIdx [6] = '{IDX_IRQ_EN, IDX_IRQ_REQ, IDX_TMR_MODE, IDX_TMR_HI, IDX_REM, 5'h03};

  mtpci_periph #(.OPT_PINT(1'b0), .CARRIER_PREDIV(PREDIV)) u_mtpci_periph (
    .mclk(mclk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .extCountPin(extCountPin), .portAIn(pinLevel[3:0]),
    .portBIn(pinLevel[7:4]), .portCIn(pinLevel[11:8]), .portDIn(pinLevel[13:12]), .portAOut(pinOut[3:0]),
    .portBOut(pinOut[7:4]), .portCOut(pinOut[11:8]), .portDOut(pinOut[13:12]), .portAOe(pinOe[3:0]),
    .portBOe(pinOe[7:4]), .portCOe(pinOe[11:8]), .portDOe(pinOe[13:12]), .portAPullup(pinPull[3:0]),
    .portBPullup(pinPull[7:4]), .portCPullup(pinPull[11:8]), .portDPullup(pinPull[13:12]),
    .carrierOutPin(carrierOutPin), .cpuIntAck(cpuIntAck), .irqPending(irqPending), .irqVector(irqVector),
    .wakeRequest(wakeRequest));
  mtpci_pins u_mtpci_pins (.mclk(mclk), .rst_n(rst_n), .pinOut(pinOut), .pinOe(pinOe), .pinPull(pinPull),
    .drvVal(drvVal), .drvEn(drvEn), .irqPending(irqPending), .ackEn(ackEn), .pinLevel(pinLevel),
    .cpuIntAck(cpuIntAck));

  task automatic stop_test;
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : stop_test
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  // request held until the edge that samples waitrequest low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [3:0] d, input logic [3:0] be);
    @(posedge mclk);
    avs_address    <= a;
    avs_writedata  <= {28'h0000000, d};
    avs_byteenable <= be;
    avs_write      <= wr;
    avs_read       <= ~wr;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata[3:0];
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask : bus
  task automatic wr(input logic [4:0] a, input logic [3:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask : wr
  task automatic rchk(input logic [4:0] a, input logic [3:0] m, input logic [3:0] exp);
    bus(1'b0, a, 4'h0, 4'hF);
    check(rd & m, exp);
  endtask : rchk
  task automatic read_tmr(output logic [7:0] v);
    bus(1'b0, IDX_TMR_HI, 4'h0, 4'hF);
    v[7:4] = rd;
    bus(1'b0, IDX_TMR_LO, 4'h0, 4'hF);
    v[3:0] = rd;
  endtask : read_tmr
  task automatic pin_req(input logic [13:0] lvl, input logic [3:0] exp);
    drvVal <= lvl;
    repeat (4) @(posedge mclk);
    rchk(IDX_IRQ_REQ, 4'h1, exp);
  endtask : pin_req
  function automatic logic [15:0] exp_car(input int osc_range_select, input int code, input int dat);
    int per;
    int hi;
    per = (code == 1 ? 8 : 12) * (osc_range_select ? PREDIV : 1);
    hi  = (code == 3 ? 6 : 4) * (osc_range_select ? PREDIV : 1);
    if (dat == 0) return 16'h0000;
    if (code == 0) return 16'h6000;
    return {8'(96 / per * hi), 8'(96 / per)};
  endfunction : exp_car

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  initial begin
    repeat (60000) @(posedge mclk);
    errors++;
    stop_test();
  end
  initial begin
    errors = 0; n_compared = 0; rst_n = 1'b0; avs_address = 5'h00; avs_read = 1'b0; avs_write = 1'b0;
    avs_writedata = 32'h00000000; avs_byteenable = 4'h0; extCountPin = 1'b0; ackEn = 1'b0;
    drvVal = 14'h3FFF; drvEn = 14'h3FFF;
    void'($urandom(32'hD3441AFA));
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    @(negedge mclk);
    check({4'h0, pinOe, pinPull}, 32'h0);
    check({carrierOutPin, irqPending, wakeRequest, irqVector, avs_waitrequest}, {3'h0, VEC_RESET, 1'b1});
    foreach (rstIdx[k])
      rchk(rstIdx[k], 4'hF, 4'h0);
    for (int i = 0; i < 4; i++) begin
      rv = 16'($urandom);
      wr(IDX_IRQ_REQ, rv[3:0]);
      wr(IDX_IRQ_EN, rv[7:4]);
      wr(IDX_TMR_MODE, {1'b0, rv[10:8]});
      wr(IDX_REM, rv[15:12]);
      rchk(IDX_IRQ_EN, 4'h5, rv[7:4] & 4'h5);
      rchk(IDX_IRQ_REQ, 4'h5, rv[3:0] & 4'h5);
      rchk(IDX_TMR_MODE, 4'h7, {1'b0, rv[10:8]});
      rchk(IDX_REM, 4'h1, {3'h0, rv[12]});
      check(irqPending, |(rv[3:0] & rv[7:4] & 4'h5));
      @(negedge mclk);
      check(carrierOutPin, rv[12]);
    end
    wr(IDX_IRQ_EN, 4'h0);
    bus(1'b1, IDX_IRQ_EN, 4'h5, 4'h0);
    rchk(IDX_IRQ_EN, 4'hF, 4'h0);
    wr(IDX_IRQ_REQ, 4'h0);
    for (int i = 0; i < 3; i++) begin
      rv = 16'($urandom);
      dv = 16'($urandom);
      for (int p = 0; p < 4; p++) begin
        wr(IDX_PORT_A + 5'(p), rv[4*p +: 4]);
        wr(IDX_DIR_A + 5'(p), dv[4*p +: 4]);
      end
      wr(IDX_PFC, {rv[15], 3'h0});
      repeat (2) @(negedge mclk);
      check(pinOe, dv[13:0]);
      check(pinOut, rv[13:0]);
      check(pinPull, rv[15] ? rv[13:0] : 14'h0000);
      for (int p = 0; p < 4; p++)
        rchk(IDX_PORT_A + 5'(p), p == 3 ? 4'h3 : 4'hF, (rv[4*p +: 4] | ~dv[4*p +: 4]) & (p == 3 ? 4'h3 : 4'hF));
    end
    for (int p = 0; p < 4; p++) wr(IDX_DIR_A + 5'(p), 4'h0);
    wr(IDX_IRQ_REQ, 4'h0);
    pin_req(14'h3FBF, 4'h1);
    wr(IDX_IRQ_REQ, 4'h0);
    pin_req(14'h37BF, 4'h0);
    pin_req(14'h3FFF, 4'h0);
    pin_req(14'h3FFD, 4'h0);
    pin_req(14'h3FFF, 4'h0);
    wr(IDX_PORT_B, 4'hF);
    wr(IDX_DIR_B, 4'h1);
    wr(IDX_PORT_B, 4'hE);
    pin_req(14'h3FFF, 4'h0);
    wr(IDX_DIR_B, 4'h0);
    pin_req(14'h3EFF, 4'h1);
    pin_req(14'h3FFF, 4'h1);
    for (int c = 0; c < 16; c++) begin
      wr(IDX_REM, {3'h0, c[0]});
      wr(IDX_PFC, {1'b0, c[3], c[2:1]});
      repeat (40) @(posedge mclk);
      @(negedge mclk);
      prev = carrierOutPin;
      highs = 0;
      rises = 0;
      repeat (96) begin
        @(negedge mclk);
        highs += int'(carrierOutPin === 1'b1);
        rises += int'(carrierOutPin === 1'b1 && prev === 1'b0);
        prev = carrierOutPin;
      end
      check({8'(highs), 8'(rises)}, exp_car(c[3], c[2:1], c[0]));
    end
    for (int e = 0; e < 2; e++) begin
      wr(IDX_EXT_CTRL, {2'h0, 1'b1, e[0]});
      extCountPin <= e[0];
      wr(IDX_TMR_MODE, 4'h7);
      wr(IDX_TMR_LO, 4'h0);
      wr(IDX_TMR_HI, 4'hF);
      wr(IDX_IRQ_REQ, 4'h1);
      for (int i = 0; i < 16; i++) begin
        if (i == 15) begin
          read_tmr(t1);
          check(t1, 8'hFF);
          rchk(IDX_IRQ_REQ, 4'h4, 4'h0);
        end
        @(posedge mclk);
        extCountPin <= ~e[0];
        repeat (4) @(posedge mclk);
        extCountPin <= e[0];
        repeat (4) @(posedge mclk);
      end
      read_tmr(t1);
      check(t1, 8'hF0);
      rchk(IDX_IRQ_REQ, 4'h5, 4'h5);
    end
    check(irqPending, 1'b0);
    wr(IDX_IRQ_EN, 4'h5);
    repeat (2) @(negedge mclk);
    check({irqPending, wakeRequest, irqVector}, {2'b11, VEC_TIMER});
    ackEn <= 1'b1;
    repeat (4) @(posedge mclk);
    ackEn <= 1'b0;
    check(irqPending, 1'b0);
    rchk(IDX_IRQ_EN, 4'hF, 4'h0);
    rchk(IDX_IRQ_REQ, 4'h5, 4'h5);
    wr(IDX_IRQ_REQ, 4'h1);
    wr(IDX_IRQ_EN, 4'h1);
    repeat (2) @(negedge mclk);
    check({irqPending, irqVector}, {1'b1, VEC_PORT});
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    @(negedge mclk);
    check({carrierOutPin, irqPending, wakeRequest, irqVector, avs_waitrequest}, {3'h0, VEC_RESET, 1'b1});
    rchk(IDX_IRQ_REQ, 4'hF, 4'h0);
    rchk(IDX_IRQ_EN, 4'hF, 4'h0);
    wr(IDX_IRQ_EN, 4'h0);
    wr(IDX_IRQ_REQ, 4'h0);
    wr(IDX_EXT_CTRL, 4'h0);
    wr(IDX_TMR_LO, 4'h0);
    wr(IDX_TMR_HI, 4'h0);
    for (int c = 7; c >= 0; c--) begin
      wr(IDX_TMR_MODE, 4'(c));
      read_tmr(t1);
      // six edges of bus traffic lie between the two counter samples
      repeat (4 * ratio[c] * (c == 0 ? 2 : 8) - 6) @(posedge mclk);
      read_tmr(t2);
      t2 = t2 - t1 - (c == 0 ? 8'h02 : 8'h08);
      check(t2 == 8'h00 || t2 == 8'h01 || t2 == 8'hFF, 1'b1);
    end
    stop_test();
  end
endmodule : mtpci_periph_tb
